// ===== include/lop_map.svh
// register map, field positions, reset values and timing counts
`ifndef LOP_MAP_SVH
`define LOP_MAP_SVH

`define LOP_IDX_PWR 10'h00F
`define LOP_IDX_DRV 10'h011
`define LOP_IDX_TERM 10'h012
`define LOP_IDX_CHAN 10'h031
`define LOP_IDX_PHASE 10'h042
`define LOP_IDX_FMT 10'h046
`define LOP_IDX_IDLE 10'h052
`define LOP_IDX_STAT 10'h060

`define LOP_MASK_PWR 16'h0F3F
`define LOP_MASK_DRV 16'h0777
`define LOP_MASK_TERM 16'h4777
`define LOP_MASK_CHAN 16'h0003
`define LOP_MASK_PHASE 16'h0060
`define LOP_MASK_FMT 16'h000C
`define LOP_MASK_IDLE 16'h0001

`define LOP_RST_PWR 16'h0000
`define LOP_RST_DRV 16'h0000
`define LOP_RST_TERM 16'h0000
`define LOP_RST_CHAN 16'h0002
`define LOP_RST_PHASE 16'h0040
`define LOP_RST_FMT 16'h0000
`define LOP_RST_IDLE 16'h0000

`define LOP_PWR_QNAP 0
`define LOP_PWR_DNAP 4
`define LOP_PWR_SLEEP 8
`define LOP_PWR_PD 9
`define LOP_PWR_PINACT 10
`define LOP_CODE_LCLK 0
`define LOP_CODE_FCLK 4
`define LOP_CODE_DAT 8
`define LOP_TERM_EN 14
`define LOP_PHASE_LSB 5
`define LOP_FMT_BTC 2
`define LOP_FMT_MSB 3

`define LOP_WAKE_LONG_CYC 64
`define LOP_BITS 8
`define LOP_LANES 8
`define LOP_CHANS 4

`endif

// ===== include/lop_pkg.sv
// types shared by the output and power block
package lop_pkg;
   typedef logic [7:0][7:0] lop_samples_t;
   typedef struct packed {
      logic bclk;
      logic bclk_oe;
      logic fclk;
      logic fclk_oe;
      logic [7:0] data;
      logic [7:0] data_oe;
   } lop_link_s;
   typedef struct packed {
      logic [2:0] drv_lclk;
      logic [2:0] drv_fclk;
      logic [2:0] drv_dat;
      logic [2:0] term_lclk;
      logic [2:0] term_fclk;
      logic [2:0] term_dat;
   } lop_analog_s;
   typedef struct packed {
      logic full_off;
      logic deep;
      logic [3:0] asleep;
      logic waking;
   } lop_power_s;
endpackage

// ===== src/lop_lane.sv
// one serial data lane: format, order and idle driver behaviour
module lop_lane
   import lop_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   input wire logic load,
   input wire logic [7:0] sample,
   input wire logic btc,
   input wire logic msb_first,
   input wire logic idle,
   input wire logic idle_drive,
   input wire logic off,
   output logic bit_out,
   output logic bit_oe
);
   typedef struct packed {
      logic [7:0] sh;
      logic o;
      logic oe;
   } lop_lane_state_s;

   lop_lane_state_s s_q;
   lop_lane_state_s s_d;
   logic [7:0] fmt;
   logic [7:0] rev;

   always_comb begin
      fmt = sample;
      fmt[7] = sample[7] ^ btc;
      for (int i = 0; i < 8; i++) begin
         rev[i] = fmt[7 - i];
      end
      s_d = s_q;
      if (load) begin
         s_d.sh = msb_first ? rev : fmt;
      end else if (tick) begin
         s_d.sh = {1'b0, s_q.sh[7:1]};
      end
      if (off) begin
         s_d.o = 1'b0;
         s_d.oe = 1'b0;
      end else if (idle) begin
         // idle lane either floats or holds a driven zero
         s_d.o = 1'b0;
         s_d.oe = idle_drive;
      end else begin
         s_d.o = s_d.sh[0];
         s_d.oe = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign bit_out = s_q.o;
   assign bit_oe = s_q.oe;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_lsb_first;
      load && !msb_first && !idle && !off |=> bit_out == $past(sample[0]);
   endproperty
   a_lsb_first: assert property (p_lsb_first)
      else $error("lsb not first after frame start");

   property p_msb_first;
      load && msb_first && !idle && !off
         |=> bit_out == ($past(sample[7]) ^ $past(btc));
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("msb not first or format wrong");

   property p_idle_hiz;
      idle && !idle_drive |=> !bit_oe;
   endproperty
   a_idle_hiz: assert property (p_idle_hiz)
      else $error("idle lane drives with driver off");

   property p_idle_zero;
      idle && idle_drive && !off |=> bit_oe && !bit_out;
   endproperty
   a_idle_zero: assert property (p_idle_zero)
      else $error("idle lane not driving zero");
endmodule

// ===== src/lop_top.sv
// output serialiser, power modes and apb register file
//
// Design decision made here: the APB register port.
`include "lop_map.svh"
module lop_top
   import lop_pkg::*;
#(
   parameter int unsigned BITS = `LOP_BITS,
   parameter int unsigned LANES = `LOP_LANES,
   parameter int unsigned WAKE_CYC = `LOP_WAKE_LONG_CYC
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic link_clk_in,
   input wire logic power_down_pin,
   input wire lop_samples_t samples,
   output lop_link_s link,
   output lop_analog_s analog,
   output lop_power_s power
);
   // serialiser and frame counter are built for this size only
   if (BITS != `LOP_BITS || LANES != `LOP_LANES) begin : g_bad_size
      $error("lop_top serves only 8 lanes of 8 bits");
   end
   if (WAKE_CYC < 1 || WAKE_CYC > 65535) begin : g_bad_wake
      $error("lop_top wake count out of range");
   end

   typedef struct packed {
      logic [15:0] pwr;
      logic [15:0] drv;
      logic [15:0] term;
      logic [15:0] chan;
      logic [15:0] phase;
      logic [15:0] fmt;
      logic [15:0] idle;
      logic [15:0] rdata;
      logic [2:0] lk_sync;
      logic [2:0] pin_sync;
      logic lk_lvl;
      logic pin_lvl;
      logic [7:0] cnt;
      logic [7:0] half;
      logic tog;
      logic bclk;
      logic bclk_oe;
      logic fclk;
      logic fclk_oe;
      logic [2:0] idx;
      logic [15:0] wake;
   } lop_top_state_s;

   lop_top_state_s s_q;
   lop_top_state_s s_d;

   ////////////////////////////////////////////////////////////////////////
   // decode helpers

   // lane to channel: dual uses four lanes a channel, quad two
   function automatic logic [1:0] lane_chan(input int unsigned lane,
                                            input logic [1:0] mode);
      if (mode == 2'b01) begin
         lane_chan = 2'(lane / 4);
      end else begin
         lane_chan = 2'(lane / 2);
      end
   endfunction

   function automatic logic mapped(input logic [9:0] idx);
      case (idx)
         `LOP_IDX_PWR, `LOP_IDX_DRV, `LOP_IDX_TERM, `LOP_IDX_CHAN,
         `LOP_IDX_PHASE, `LOP_IDX_FMT, `LOP_IDX_IDLE,
         `LOP_IDX_STAT: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // power state

   logic [9:0] ridx;
   logic pin_hi;
   logic [1:0] pin_act;
   logic full_off;
   logic deep;
   logic pin_nap;
   logic [3:0] nap;
   logic [3:0] asleep;
   logic waking;
   logic lk_tick;
   logic frame_start;
   logic wr_en;
   logic [15:0] stat;
   logic [1:0] ph;

   assign ridx = paddr[11:2];
   assign pin_hi = s_q.pin_lvl;
   assign pin_act = s_q.pwr[`LOP_PWR_PINACT +: 2];
   assign full_off = s_q.pwr[`LOP_PWR_PD] ||
                     (pin_hi && pin_act == 2'b00);
   assign deep = s_q.pwr[`LOP_PWR_SLEEP] ||
                 (pin_hi && pin_act == 2'b10);
   assign pin_nap = pin_hi && pin_act[0];
   assign waking = s_q.wake != 16'h0000;
   assign ph = s_q.phase[`LOP_PHASE_LSB +: 2];

   always_comb begin
      for (int c = 0; c < 4; c++) begin
         if (s_q.chan[1:0] == 2'b01) begin
            nap[c] = (c < 2) && s_q.pwr[`LOP_PWR_DNAP + c];
         end else begin
            nap[c] = s_q.pwr[`LOP_PWR_QNAP + c];
         end
         asleep[c] = nap[c] || pin_nap || deep || full_off;
      end
   end

   assign stat = {8'h00, s_q.pin_lvl, waking, asleep, deep, full_off};
   assign wr_en = psel && penable && pwrite;
   assign lk_tick = s_q.lk_lvl != s_q.lk_sync[2] &&
                    s_q.lk_sync[1] == s_q.lk_sync[2];
   assign frame_start = lk_tick && s_q.idx == 3'd7;

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_d = s_q;
      // third flop filters: a level counts once stages 2 and 3 agree
      s_d.lk_sync = {s_q.lk_sync[1:0], link_clk_in};
      s_d.pin_sync = {s_q.pin_sync[1:0], power_down_pin};
      if (s_q.lk_sync[1] == s_q.lk_sync[2]) begin
         s_d.lk_lvl = s_q.lk_sync[2];
      end
      if (s_q.pin_sync[1] == s_q.pin_sync[2]) begin
         s_d.pin_lvl = s_q.pin_sync[2];
      end

      if (psel && !penable) begin
         unique case (ridx)
            `LOP_IDX_PWR: s_d.rdata = s_q.pwr;
            `LOP_IDX_DRV: s_d.rdata = s_q.drv;
            `LOP_IDX_TERM: s_d.rdata = s_q.term;
            `LOP_IDX_CHAN: s_d.rdata = s_q.chan;
            `LOP_IDX_PHASE: s_d.rdata = s_q.phase;
            `LOP_IDX_FMT: s_d.rdata = s_q.fmt;
            `LOP_IDX_IDLE: s_d.rdata = s_q.idle;
            `LOP_IDX_STAT: s_d.rdata = stat;
            default: s_d.rdata = 16'h0000;
         endcase
      end
      if (wr_en) begin
         unique case (ridx)
            `LOP_IDX_PWR: s_d.pwr = pwdata[15:0] & `LOP_MASK_PWR;
            `LOP_IDX_DRV: s_d.drv = pwdata[15:0] & `LOP_MASK_DRV;
            `LOP_IDX_TERM: s_d.term = pwdata[15:0] & `LOP_MASK_TERM;
            `LOP_IDX_CHAN: s_d.chan = pwdata[15:0] & `LOP_MASK_CHAN;
            `LOP_IDX_PHASE: s_d.phase = pwdata[15:0] & `LOP_MASK_PHASE;
            `LOP_IDX_FMT: s_d.fmt = pwdata[15:0] & `LOP_MASK_FMT;
            `LOP_IDX_IDLE: s_d.idle = pwdata[15:0] & `LOP_MASK_IDLE;
            default: ;
         endcase
      end

      // long wake after deep sleep or power-down, as for a cold start
      if (full_off || deep) begin
         s_d.wake = 16'(WAKE_CYC);
      end else if (waking) begin
         s_d.wake = s_q.wake - 16'h0001;
      end

      // bit period measured between link edges, half used for 90 deg
      if (lk_tick) begin
         s_d.cnt = 8'h00;
         s_d.half = {1'b0, s_q.cnt[7:1]};
         s_d.idx = s_q.idx + 3'd1;
      end else if (s_q.cnt != 8'hFF) begin
         s_d.cnt = s_q.cnt + 8'h01;
      end
      if (ph[1] ? (!lk_tick && s_q.cnt == s_q.half) : lk_tick) begin
         s_d.tog = !s_q.tog;
      end
      s_d.bclk = s_d.tog ^ ph[0];
      s_d.fclk = s_d.idx < 3'd4;
      // clocks keep running in both sleeps, only power-down floats them
      s_d.bclk_oe = !full_off;
      s_d.fclk_oe = !full_off;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.pwr <= `LOP_RST_PWR;
         s_q.drv <= `LOP_RST_DRV;
         s_q.term <= `LOP_RST_TERM;
         s_q.chan <= `LOP_RST_CHAN;
         s_q.phase <= `LOP_RST_PHASE;
         s_q.fmt <= `LOP_RST_FMT;
         s_q.idle <= `LOP_RST_IDLE;
         s_q.idx <= 3'd7;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // lanes

   for (genvar l = 0; l < LANES; l++) begin : g_lane
      lop_lane u_lane (
         .pclk(pclk),
         .presetn(presetn),
         .tick(lk_tick),
         .load(frame_start),
         .sample(samples[l]),
         .btc(s_q.fmt[`LOP_FMT_BTC]),
         .msb_first(s_q.fmt[`LOP_FMT_MSB]),
         .idle(asleep[lane_chan(l, s_q.chan[1:0])] || waking),
         .idle_drive(s_q.idle[0]),
         .off(full_off),
         .bit_out(link.data[l]),
         .bit_oe(link.data_oe[l])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign prdata = {16'h0000, s_q.rdata};
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped(ridx);
   assign link.bclk = s_q.bclk;
   assign link.bclk_oe = s_q.bclk_oe;
   assign link.fclk = s_q.fclk;
   assign link.fclk_oe = s_q.fclk_oe;
   assign analog.drv_lclk = s_q.drv[`LOP_CODE_LCLK +: 3];
   assign analog.drv_fclk = s_q.drv[`LOP_CODE_FCLK +: 3];
   assign analog.drv_dat = s_q.drv[`LOP_CODE_DAT +: 3];
   assign analog.term_lclk = s_q.term[`LOP_TERM_EN] ?
                             s_q.term[`LOP_CODE_LCLK +: 3] : 3'h0;
   assign analog.term_fclk = s_q.term[`LOP_TERM_EN] ?
                             s_q.term[`LOP_CODE_FCLK +: 3] : 3'h0;
   assign analog.term_dat = s_q.term[`LOP_TERM_EN] ?
                            s_q.term[`LOP_CODE_DAT +: 3] : 3'h0;
   assign power.full_off = full_off;
   assign power.deep = deep;
   assign power.asleep = asleep;
   assign power.waking = waking;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_pin_rise;
      $rose(s_q.pin_lvl);
   endsequence

   property p_pd_hiz;
      full_off |=> !link.bclk_oe && !link.fclk_oe;
   endproperty
   a_pd_hiz: assert property (p_pd_hiz)
      else $error("clocks driven during power-down");

   property p_sleep_clk;
      (deep || pin_nap) && !full_off |=> link.bclk_oe && link.fclk_oe;
   endproperty
   a_sleep_clk: assert property (p_sleep_clk)
      else $error("clock driver off during sleep");

   property p_pin_pd;
      s_pin_rise ##0 pin_act == 2'b00 |-> full_off;
   endproperty
   a_pin_pd: assert property (p_pin_pd)
      else $error("pin did not power down");

   property p_pin_deep;
      s_pin_rise ##0 pin_act == 2'b10 && !full_off |-> deep ##1 link.fclk_oe;
   endproperty
   a_pin_deep: assert property (p_pin_deep)
      else $error("pin deep sleep wrong");

   property p_pin_nap;
      s_q.pin_lvl && pin_act[0] |-> asleep == 4'hF;
   endproperty
   a_pin_nap: assert property (p_pin_nap)
      else $error("pin nap missed a channel");

   property p_term_gate;
      !s_q.term[`LOP_TERM_EN] |-> analog.term_dat == 3'h0 &&
         analog.term_lclk == 3'h0 && analog.term_fclk == 3'h0;
   endproperty
   a_term_gate: assert property (p_term_gate)
      else $error("termination active while disabled");

   property p_edge_align;
      lk_tick && !ph[1] && $stable(ph) |=> $changed(s_q.bclk);
   endproperty
   a_edge_align: assert property (p_edge_align)
      else $error("bit clock not toggled at bit edge");

   property p_mid_bit;
      lk_tick && ph == 2'b10 && $stable(ph) |=> $stable(s_q.bclk);
   endproperty
   a_mid_bit: assert property (p_mid_bit)
      else $error("bit clock edge not mid-bit");

   property p_frame;
      lk_tick && s_q.idx == 3'd3 |=> !link.fclk ##0 s_q.idx == 3'd4;
   endproperty
   a_frame: assert property (p_frame)
      else $error("frame clock not low after four bits");
endmodule

// ===== tb/lop_rx_model.sv
// far-end receiver model: makes the link clock, deframes the lanes
module lop_rx_model
   import lop_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire lop_link_s link,
   output logic link_clk,
   output logic [7:0][7:0] word,
   output int frames,
   output int bclk_edges,
   output int skew_hits
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [7:0][7:0] shift;
   logic last_bclk;
   logic fclk_at_edge;
   logic [7:0] last_data;
   int k;

   // odd start offset keeps link clock edges off pclk edges
   initial begin
      link_clk = 1'b0;
      #137;
      forever #200 link_clk = ~link_clk;
   end

   ////////////////////////////////////////////////////////////////////
   // capture on both bit clock edges, frame start from frame clock rise
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_bclk <= 1'b0;
         last_data <= 8'h00;
         fclk_at_edge <= 1'b0;
         k = 0;
         frames <= 0;
         bclk_edges <= 0;
         skew_hits <= 0;
         word <= '0;
         shift = '0;
      end else begin
         last_bclk <= link.bclk;
         last_data <= link.data;
         // a data change on a bit clock edge means no mid-window strobe
         if (link.bclk_oe && link.bclk != last_bclk &&
               link.data != last_data) begin
            skew_hits <= skew_hits + 1;
         end
         if (link.bclk_oe && link.bclk != last_bclk) begin
            bclk_edges <= bclk_edges + 1;
            fclk_at_edge <= link.fclk;
            k = (link.fclk && !fclk_at_edge) ? 0 : k + 1;
            if (k < 8) begin
               for (int l = 0; l < 8; l++) begin
                  shift[l][k] = link.data[l];
               end
            end
            if (k == 7) begin
               word <= shift;
               frames <= frames + 1;
            end
         end
      end
   end
endmodule

// ===== tb/tb_lvds_output_and_power_modes.sv
// bench: apb access, serial format, sleep and power-down behaviour
`include "lop_map.svh"
module tb_lvds_output_and_power_modes
   import lop_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic link_clk, err;
   lop_samples_t samples;
   lop_link_s link;
   lop_analog_s analog;
   lop_power_s power;
   logic [7:0][7:0] word;
   int frames, bclk_edges, skew_hits, err_total, tests_run, e0;
   logic [9:0] ix [7] = '{`LOP_IDX_PWR, `LOP_IDX_DRV, `LOP_IDX_TERM,
      `LOP_IDX_CHAN, `LOP_IDX_PHASE, `LOP_IDX_FMT, `LOP_IDX_IDLE};
   logic [15:0] rv [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0002,
      16'h0040, 16'h0000, 16'h0000};
   logic [15:0] mk [7] = '{`LOP_MASK_PWR, `LOP_MASK_DRV, `LOP_MASK_TERM,
      `LOP_MASK_CHAN, `LOP_MASK_PHASE, `LOP_MASK_FMT, `LOP_MASK_IDLE};
   logic [7:0] e, e2;

   lop_top #(.WAKE_CYC(4)) u_lop_top (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link_clk_in(link_clk),
      .power_down_pin(pin), .samples(samples), .link(link),
      .analog(analog), .power(power));

   lop_rx_model u_lop_rx_model (.pclk(pclk), .presetn(presetn),
      .link(link), .link_clk(link_clk), .word(word), .frames(frames),
      .bclk_edges(bclk_edges), .skew_hits(skew_hits));

   always #25 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////
   task automatic conclude;
      if (err_total == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one apb transfer, then an idle cycle so psel is never set twice
   task automatic apb(input logic wr, input logic [9:0] idx,
         input logic [15:0] wd);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {16'h0000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_total++;
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic frames_wait(input int n);
      int f0, c;
      f0 = frames;
      c = 0;
      while (frames < f0 + n && c < 2000) begin
         @(posedge pclk);
         c++;
      end
      if (c >= 2000) begin
         err_total++;
         conclude();
      end
   endtask

   initial begin
      #2000000;
      err_total++;
      conclude();
   end

   ////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pin = 1'b0;
      err_total = 0;
      tests_run = 0;
      for (int l = 0; l < 8; l++) samples[l] = {1'b1, 3'(l), 4'h6};
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // reset values, masking of unassigned bits, restore
      for (int i = 0; i < 7; i++) begin
         apb(1'b0, ix[i], 16'h0000);
         chk(rd, {16'h0000, rv[i]});
         apb(1'b1, ix[i], 16'hFFFF);
         apb(1'b0, ix[i], 16'h0000);
         chk(rd, {16'h0000, mk[i]});
         apb(1'b1, ix[i], rv[i]);
      end
      apb(1'b1, 10'h3FF, 16'hFFFF);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 10'h3FF, 16'h0000);
      chk(rd, 32'h0);
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, `LOP_IDX_DRV, {5'h0, 3'(c), 1'b0, 3'(c), 1'b0, 3'(c)});
         chk({analog.drv_lclk, analog.drv_fclk, analog.drv_dat},
            {3{3'(c)}});
         apb(1'b1, `LOP_IDX_TERM, {5'h0, 3'(c), 1'b0, 3'(c), 1'b0, 3'(c)});
         chk({analog.term_lclk, analog.term_fclk, analog.term_dat},
            9'h0);
         apb(1'b1, `LOP_IDX_TERM, {5'h08, 3'(c), 1'b0, 3'(c), 1'b0, 3'(c)});
         chk({analog.term_lclk, analog.term_fclk, analog.term_dat},
            {3{3'(c)}});
      end
      // reduced swing drive for the rest of the run
      apb(1'b1, `LOP_IDX_DRV, 16'h0222);
      chk({analog.drv_lclk, analog.drv_fclk, analog.drv_dat},
         {3{3'b010}});
      // serial format in all four format/order combinations
      e0 = skew_hits;
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, `LOP_IDX_FMT, {12'h000, 2'(m), 2'b00});
         frames_wait(3);
         for (int l = 0; l < 8; l++) begin
            e = samples[l] ^ (m[0] ? 8'h80 : 8'h00);
            for (int b = 0; b < 8; b++) e2[b] = m[1] ? e[7 - b] : e[b];
            chk(word[l], e2);
         end
      end
      chk(skew_hits, e0);
      apb(1'b1, `LOP_IDX_PHASE, 16'h0000);
      frames_wait(2);
      chk({31'h0, skew_hits > e0}, 32'h1);
      e0 = skew_hits;
      apb(1'b1, `LOP_IDX_PHASE, 16'h0020);
      frames_wait(2);
      chk({31'h0, skew_hits > e0}, 32'h1);
      apb(1'b1, `LOP_IDX_PHASE, 16'h0040);
      // light sleep of channel 0, idle drivers off then driving zero
      e0 = bclk_edges;
      apb(1'b1, `LOP_IDX_PWR, 16'h0001);
      settle(16);
      chk({power.asleep, link.data_oe, link.data[1:0]}, 14'h07F0);
      chk({link.bclk_oe, link.fclk_oe}, 2'b11);
      chk({31'h0, bclk_edges > e0}, 32'h1);
      apb(1'b1, `LOP_IDX_IDLE, 16'h0001);
      settle(16);
      chk({link.data_oe, link.data[1:0]}, 10'h3FC);
      apb(1'b1, `LOP_IDX_IDLE, 16'h0000);
      apb(1'b1, `LOP_IDX_CHAN, 16'h0001);
      apb(1'b1, `LOP_IDX_PWR, 16'h0010);
      settle(16);
      chk({power.asleep[0], link.data_oe}, 9'h1F0);
      apb(1'b1, `LOP_IDX_CHAN, 16'h0002);
      apb(1'b1, `LOP_IDX_PWR, 16'h0100);
      settle(16);
      chk({power.deep, link.bclk_oe, link.fclk_oe, link.data_oe},
         11'h700);
      apb(1'b1, `LOP_IDX_PWR, 16'h0200);
      settle(16);
      chk({power.full_off, link.bclk_oe, link.fclk_oe, link.data_oe},
         11'h400);
      // pin action codes, pin raised from an awake state
      for (int a = 0; a < 4; a++) begin
         apb(1'b1, `LOP_IDX_PWR, {4'h0, 2'(a), 10'h000});
         settle(16);
         pin <= 1'b1;
         settle(16);
         chk({power.full_off, power.deep}, {a == 0, a == 2});
         if (a[0]) begin
            chk({power.asleep, link.data_oe}, 12'hF00);
         end
         apb(1'b0, `LOP_IDX_STAT, 16'h0000);
         chk(rd, {24'h0, 1'b1, a[0] == 1'b0, 4'hF, a == 2, a == 0});
         pin <= 1'b0;
         settle(16);
      end
      conclude();
   end
endmodule
